/* macc_pkg.sv */
// Overview of operation
// - operation inferred from operand access order
// - 32/16 divide, quotient, remainder, 36 periods
// - 16/16 divide, quotient, remainder, 24 periods
// - normalize and shift finish within 36
// - divide loads A LSB first, then B
// - divide busy, then quotient, remainder MSB first
// - multiply loads B then A, product read
// - shift loads A, writes setup, reads result
// - normalize loads A, setup zero, reads mantissa
// - never normalize a zero value
// - unrelated accesses between operand accesses tolerated
// - out-of-order access corrupts; busy clear restarts
// - multiply and divide results added to accumulator
// - accumulator via five operand C accesses
package macc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // special function register addresses
   localparam logic [7:0] ADDR_SHIFT_SETUP = 8'hd1;
   localparam logic [7:0] ADDR_STATUS = 8'hd2;
   localparam logic [7:0] ADDR_OPA = 8'hd3;
   localparam logic [7:0] ADDR_OPB = 8'hd4;
   localparam logic [7:0] ADDR_OPC = 8'hd5;

   // field positions and reset values
   localparam int STATUS_BUSY_BIT = 7;
   localparam int SETUP_LEFT_BIT = 7;
   localparam int SETUP_AMT_W = 5;
   localparam logic [7:0] SETUP_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // execution times in oscillator periods, counts in clk_in cycles
   localparam int CLK_NS = 20;
   localparam int TCLCL_NS = 20;
   localparam int EXEC_DIV32_TCLCL = 36;
   localparam int EXEC_DIV16_TCLCL = 24;
   localparam int EXEC_MUL_TCLCL = 24;
   localparam int EXEC_SHIFT_TCLCL = 36;
   localparam int EXEC_NORM_TCLCL = 36;
   localparam int CYC_DIV32 = EXEC_DIV32_TCLCL * TCLCL_NS / CLK_NS;
   localparam int CYC_DIV16 = EXEC_DIV16_TCLCL * TCLCL_NS / CLK_NS;
   localparam int CYC_MUL = EXEC_MUL_TCLCL * TCLCL_NS / CLK_NS;
   localparam int CYC_SHIFT = EXEC_SHIFT_TCLCL * TCLCL_NS / CLK_NS;
   localparam int CYC_NORM = EXEC_NORM_TCLCL * TCLCL_NS / CLK_NS;
   localparam int CNT_W = 6;

   ////////////////////////////////////////////////////////////////////////////
   // controller apb map
   localparam logic [11:0] APB_CMD_OFS = 12'h000;
   localparam logic [11:0] APB_RESULT_OFS = 12'h004;
   localparam int CMD_ADDR_LSB = 0;
   localparam int CMD_DATA_LSB = 8;
   localparam int CMD_WRITE_BIT = 16;
   localparam int RES_DATA_LSB = 0;
   localparam int RES_PEND_BIT = 8;

   // operations and sequencer states
   typedef enum {OP_NONE, OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM} macc_op_t;
   typedef enum {SQ_IDLE, SQ_A_LOAD, SQ_B_DIV, SQ_B_MUL, SQ_A_MUL, SQ_RUN, SQ_FAULT} macc_seq_t;

endpackage

/* macc_sfr_if.sv */
`timescale 1ns/100ps
// byte-wide special function register access path
interface macc_sfr_if;
   logic [7:0] addr;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport dev (input addr, input wr_stb, input rd_stb, input wdata, output rdata);
   modport host (output addr, output wr_stb, output rd_stb, output wdata, input rdata);
endinterface

/* macc_device.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module macc_device
#(
   parameter int ACC_W = 40
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // register access from the core
   macc_sfr_if.dev sfr,
   // user side status
   output logic busy_out,
   output logic [ACC_W-1:0] accum_out
);
   import macc_pkg::*;

   // accumulator must hold a full product or quotient
   if (ACC_W < 32 || ACC_W > 64)
   begin : g_bad_width
      $error("macc_device: ACC_W must be 32 to 64");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   macc_seq_t state;
   macc_seq_t next_state;
   macc_op_t op;
   macc_op_t next_op;
   logic [2:0] na;
   logic [2:0] next_na;
   logic [1:0] nb;
   logic [1:0] next_nb;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic start;
   logic finish;
   logic [31:0] op_a;
   logic [15:0] op_b;
   logic [31:0] res_a;
   logic [15:0] res_b;
   logic [7:0] shift_setup_reg;
   logic [ACC_W-1:0] acc;
   logic [7:0] rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   wire hit_a = sfr.addr == ADDR_OPA;
   wire hit_b = sfr.addr == ADDR_OPB;
   wire hit_c = sfr.addr == ADDR_OPC;
   wire wr_a = sfr.wr_stb & hit_a;
   wire wr_b = sfr.wr_stb & hit_b;
   wire wr_c = sfr.wr_stb & hit_c;
   wire rd_a = sfr.rd_stb & hit_a;
   wire rd_b = sfr.rd_stb & hit_b;
   wire rd_c = sfr.rd_stb & hit_c;
   wire wr_setup = sfr.wr_stb & (sfr.addr == ADDR_SHIFT_SETUP);
   wire wr_status = sfr.wr_stb & (sfr.addr == ADDR_STATUS);
   // only a written zero in the busy bit restarts the sequencer
   wire clr_busy = wr_status & ~sfr.wdata[STATUS_BUSY_BIT];
   wire any_ab = wr_a | wr_b | rd_a | rd_b;
   wire any_abc = any_ab | wr_c | rd_c;
   wire busy = (state == SQ_RUN) || (state == SQ_FAULT);

   ////////////////////////////////////////////////////////////////////////////
   // arithmetic, evaluated on the latched operands
   function automatic logic [SETUP_AMT_W-1:0] lead_zeros(input logic [31:0] v);
      logic [SETUP_AMT_W-1:0] n;
      logic found;
      n = '0;
      found = 1'b0;
      for (int i = 31; i >= 0; i--)
      begin
         if (!found && v[i])
         begin
            n = SETUP_AMT_W'(31 - i);
            found = 1'b1;
         end
      end
      return n;
   endfunction

   wire [31:0] dividend = (op == OP_DIV32) ? op_a : {16'h0000, op_a[31:16]};
   wire div_zero = op_b == 16'h0000;
   // divide by zero gives all ones and keeps the low 16 bits of the dividend as remainder
   wire [31:0] quot = div_zero ? 32'hffffffff : dividend / {16'h0000, op_b};
   wire [15:0] rem = div_zero ? dividend[15:0] : 16'(dividend % {16'h0000, op_b});
   wire [31:0] prod = op_a[31:16] * op_b;
   wire [SETUP_AMT_W-1:0] amt = shift_setup_reg[SETUP_AMT_W-1:0];
   wire [31:0] shifted = shift_setup_reg[SETUP_LEFT_BIT] ? op_a << amt : op_a >> amt;
   wire [SETUP_AMT_W-1:0] exp_lz = lead_zeros(op_a);
   wire [31:0] mant = op_a << exp_lz;
   // a zero normalize never ends; software must avoid it or clear busy
   wire norm_stuck = (op == OP_NORM) && (op_a == 32'h00000000);
   wire [31:0] add_val = (op == OP_MUL) ? prod : quot;

   // read data selection
   wire [7:0] status_val = {busy, 7'h00};
   wire [7:0] rd_mux = hit_a ? res_a[31:24] :
                       hit_b ? res_b[15:8] :
                       hit_c ? acc[ACC_W-1 -: 8] :
                       (sfr.addr == ADDR_STATUS) ? status_val :
                       (sfr.addr == ADDR_SHIFT_SETUP) ? shift_setup_reg : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // access-order sequencer; addresses other than the operands, setup and status never move it
   always_comb
   begin
      next_state = state;
      next_op = op;
      next_na = na;
      next_nb = nb;
      start = 1'b0;
      finish = 1'b0;
      next_cnt = cnt;
      if (clr_busy)
         next_state = SQ_IDLE;
      else
      begin
         unique case (state)
            SQ_IDLE:
            begin
               // result reads and accumulator access are legal here
               if (wr_a)
               begin
                  next_state = SQ_A_LOAD;
                  next_na = 3'd1;
               end
               else if (wr_b)
               begin
                  next_state = SQ_B_MUL;
                  next_nb = 2'd1;
               end
            end
            SQ_A_LOAD:
            begin
               if (wr_a && na < 3'd4)
                  next_na = na + 3'd1;
               else if (wr_b && (na == 3'd2 || na == 3'd4))
                  next_state = SQ_B_DIV;
               else if (wr_setup && na == 3'd4)
               begin
                  start = 1'b1;
                  next_op = (sfr.wdata == 8'h00) ? OP_NORM : OP_SHIFT;
               end
               else if (wr_setup || any_abc)
                  next_state = SQ_FAULT;
            end
            SQ_B_DIV:
            begin
               if (wr_b)
               begin
                  start = 1'b1;
                  next_op = (na == 3'd4) ? OP_DIV32 : OP_DIV16;
               end
               else if (any_abc)
                  next_state = SQ_FAULT;
            end
            SQ_B_MUL:
            begin
               if (wr_b && nb == 2'd1)
                  next_nb = 2'd2;
               else if (wr_a && nb == 2'd2)
                  next_state = SQ_A_MUL;
               else if (any_abc)
                  next_state = SQ_FAULT;
            end
            SQ_A_MUL:
            begin
               if (wr_a)
               begin
                  start = 1'b1;
                  next_op = OP_MUL;
               end
               else if (any_abc)
                  next_state = SQ_FAULT;
            end
            SQ_RUN:
            begin
               if (any_abc)
                  next_state = SQ_FAULT;
               else if (cnt != '0)
                  next_cnt = cnt - 1'b1;
               else if (!norm_stuck)
               begin
                  finish = 1'b1;
                  next_state = SQ_IDLE;
               end
            end
            SQ_FAULT:
               next_state = SQ_FAULT;
         endcase
      end
      if (start)
      begin
         next_state = SQ_RUN;
         unique case (next_op)
            OP_DIV32: next_cnt = CNT_W'(CYC_DIV32 - 1);
            OP_DIV16: next_cnt = CNT_W'(CYC_DIV16 - 1);
            OP_MUL: next_cnt = CNT_W'(CYC_MUL - 1);
            OP_SHIFT: next_cnt = CNT_W'(CYC_SHIFT - 1);
            default: next_cnt = CNT_W'(CYC_NORM - 1);
         endcase
      end
   end

   // sequencer registers; busy_out is taken from next_state, so it follows the state it enters
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         state <= SQ_IDLE;
         op <= OP_NONE;
         na <= 3'd0;
         nb <= 2'd0;
         cnt <= '0;
         busy_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         op <= next_op;
         na <= next_na;
         nb <= next_nb;
         cnt <= next_cnt;
         busy_out <= (next_state == SQ_RUN) || (next_state == SQ_FAULT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand capture, lsb first into the top of the shifter
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         op_a <= 32'h00000000;
         op_b <= 16'h0000;
      end
      else
      begin
         if (wr_a && !busy)
            op_a <= {sfr.wdata, op_a[31:8]};
         if (wr_b && !busy)
            op_b <= {sfr.wdata, op_b[15:8]};
      end
   end

   // results: read msb first by shifting out the top byte
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         res_a <= 32'h00000000;
         res_b <= 16'h0000;
         shift_setup_reg <= SETUP_RESET;
      end
      else if (finish)
      begin
         unique case (op)
            OP_DIV32: res_a <= quot;
            OP_DIV16: res_a <= {quot[15:0], 16'h0000};
            OP_MUL: res_a <= prod;
            OP_SHIFT: res_a <= shifted;
            default: res_a <= mant;
         endcase
         res_b <= rem;
         // exponent lands in the amount field so software can read it
         if (op == OP_NORM)
            shift_setup_reg[SETUP_AMT_W-1:0] <= exp_lz;
      end
      else
      begin
         if (rd_a && state == SQ_IDLE)
            res_a <= {res_a[23:0], 8'h00};
         if (rd_b && state == SQ_IDLE)
            res_b <= {res_b[7:0], 8'h00};
         if (wr_setup && !busy)
            shift_setup_reg <= sfr.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator: adds multiply and divide results, or five byte accesses when idle
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         acc <= '0;
      else if (finish && (op == OP_MUL || op == OP_DIV32 || op == OP_DIV16))
         acc <= acc + {{(ACC_W-32){1'b0}}, add_val};
      else if (wr_c && state == SQ_IDLE)
         acc <= {sfr.wdata, acc[ACC_W-1:8]};
      else if (rd_c && state == SQ_IDLE)
         acc <= {acc[ACC_W-9:0], acc[ACC_W-1 -: 8]};
   end

   // read data returns one edge after the strobe
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         rdata_q <= 8'h00;
      else if (sfr.rd_stb)
         rdata_q <= rd_mux;
   end

   assign sfr.rdata = rdata_q;
   assign accum_out = acc;

endmodule

/* macc_host.sv */
`timescale 1ns/100ps
module macc_host
(
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // apb slave
   input wire logic [11:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // register access toward the accelerator
   macc_sfr_if.host sfr
);
   import macc_pkg::*;

   logic [7:0] addr_q;
   logic [7:0] wdata_q;
   logic wr_q;
   logic rd_q;
   logic rd_wait;
   logic pend;
   logic [7:0] result;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire access = psel_in & penable_in;
   wire hit_cmd = paddr_in == APB_CMD_OFS;
   wire hit_res = paddr_in == APB_RESULT_OFS;
   // a command while one is in flight stalls the bus, never dropped
   wire stall = hit_cmd & pwrite_in & pend;
   wire next_pready = access & ~pready_out & ~stall;
   wire done = access & pready_out;
   wire cmd_take = done & hit_cmd & pwrite_in;
   wire [31:0] rd_mux = hit_res ? {23'h000000, pend, result} : 32'h00000000;

   // bus answer, one wait cycle per transfer
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end
      else
      begin
         pready_out <= next_pready;
         pslverr_out <= next_pready & ~hit_cmd & ~hit_res;
         if (next_pready && !pwrite_in)
            prdata_out <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one register access per command; order is software's duty
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rd_wait <= 1'b0;
         pend <= 1'b0;
         result <= 8'h00;
      end
      else
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         if (cmd_take)
         begin
            addr_q <= pwdata_in[CMD_ADDR_LSB +: 8];
            wdata_q <= pwdata_in[CMD_DATA_LSB +: 8];
            wr_q <= pwdata_in[CMD_WRITE_BIT];
            rd_q <= ~pwdata_in[CMD_WRITE_BIT];
            pend <= 1'b1;
         end
         else if (wr_q)
            pend <= 1'b0;
         else if (rd_q)
            rd_wait <= 1'b1;
         else if (rd_wait)
         begin
            result <= sfr.rdata;
            rd_wait <= 1'b0;
            pend <= 1'b0;
         end
      end
   end

   assign sfr.addr = addr_q;
   assign sfr.wdata = wdata_q;
   assign sfr.wr_stb = wr_q;
   assign sfr.rd_stb = rd_q;

endmodule

/* macc_props.sv */
`timescale 1ns/100ps
module macc_props
import macc_pkg::*;
#(
   parameter int ACC_W = 40
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // register link
   input wire logic [7:0] addr,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   // device status
   input wire logic busy_out,
   input wire logic [ACC_W-1:0] accum_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   logic [7:0] run_cnt;
   logic clr_wr;
   logic acc_touch;

   ////////////////////////////////////////////////////////////////////////////
   // decoded causes, named so that $past sees plain signals
   assign clr_wr = wr_stb && addr == ADDR_STATUS && !wdata[STATUS_BUSY_BIT];
   assign acc_touch = (wr_stb || rd_stb) && addr == ADDR_OPC;

   // length of the current busy stretch, saturating so a hung normalize cannot wrap
   always_ff @(posedge clk_in)
   begin
      if (srst_in || !busy_out)
         run_cnt <= 8'h00;
      else if (run_cnt != 8'hff)
         run_cnt <= run_cnt + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   busy_start_a: assert property ($rose(busy_out) |-> $past(wr_stb))
      else $error("busy rose without a write");
   busy_len_a: assert property ($fell(busy_out) |->
      run_cnt == 8'(CYC_DIV16) || run_cnt == 8'(CYC_DIV32) || run_cnt == 8'(CYC_MUL) ||
      run_cnt == 8'(CYC_SHIFT) || run_cnt == 8'(CYC_NORM) || $past(clr_wr))
      else $error("busy length wrong");
   clear_stops_a: assert property (clr_wr |=> !busy_out)
      else $error("busy clear ignored");
   strobe_pulse_a: assert property (wr_stb || rd_stb |=> !wr_stb && !rd_stb)
      else $error("strobe longer than one cycle");
   strobe_excl_a: assert property (!(wr_stb && rd_stb))
      else $error("read and write strobe together");
   rdata_cause_a: assert property (!$stable(rdata) |-> $past(rd_stb) || $past(srst_in))
      else $error("read data changed without a read");
   status_read_a: assert property (rd_stb && addr == ADDR_STATUS |=> rdata == {$past(busy_out), 7'h00})
      else $error("status read wrong");
   accum_cause_a: assert property (!$stable(accum_out) |->
      $fell(busy_out) || $past(acc_touch) || $past(srst_in))
      else $error("accumulator changed without cause");

   // main scenarios reached
   cover property ($fell(busy_out) && run_cnt == 8'(CYC_DIV32));
   cover property ($fell(busy_out) && run_cnt == 8'(CYC_DIV16));
   cover property (clr_wr && busy_out);
endmodule

/* math_accelerator_tb.sv */
`timescale 1ns/100ps
module math_accelerator_tb;
   import macc_pkg::*;
   logic clk_in;
   logic srst_in;
   logic [11:0] paddr;
   logic psel, penable, pwrite;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, busy;
   logic [39:0] accum;
   int failures;
   int n_checks;

   ////////////////////////////////////////////////////////////////////////////
   // both ends joined through the register link
   macc_sfr_if macc_sfr_if_inst();
   macc_host macc_host_inst (.clk_in(clk_in), .srst_in(srst_in), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .sfr(macc_sfr_if_inst.host));
   macc_device #(.ACC_W(40)) macc_device_inst (.clk_in(clk_in), .srst_in(srst_in),
      .sfr(macc_sfr_if_inst.dev), .busy_out(busy), .accum_out(accum));
   macc_props #(.ACC_W(40)) macc_props_inst (.clk_in(clk_in), .srst_in(srst_in),
      .addr(macc_sfr_if_inst.addr), .wr_stb(macc_sfr_if_inst.wr_stb), .rd_stb(macc_sfr_if_inst.rd_stb),
      .wdata(macc_sfr_if_inst.wdata), .rdata(macc_sfr_if_inst.rdata), .busy_out(busy), .accum_out(accum));

   // 50 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task hang;
      failures++;
      complete_run();
   endtask

   task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic err);
      int i;
      @(posedge clk_in);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk_in);
         i++;
      end
      while (pready !== 1'b1 && i < 100);
      if (i >= 100)
         hang();
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task sfr_wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, APB_CMD_OFS, {15'h0000, 1'b1, d, a}, q, e);
   endtask

   // issue a read command, then poll the result word until it is no longer pending
   task sfr_rd(input logic [7:0] a, output logic [7:0] d);
      logic [31:0] q;
      logic e;
      int i;
      apb(1'b1, APB_CMD_OFS, {24'h000000, a}, q, e);
      i = 0;
      do
      begin
         apb(1'b0, APB_RESULT_OFS, 32'h00000000, q, e);
         i++;
      end
      while (q[RES_PEND_BIT] !== 1'b0 && i < 20);
      if (i >= 20)
         hang();
      d = q[7:0];
   endtask

   // operand bytes go least significant first, results come back most significant first
   task load(input logic [7:0] a, input logic [31:0] v, input int n);
      for (int i = 0; i < n; i++)
         sfr_wr(a, v[i*8 +: 8]);
   endtask

   task fetch(input logic [7:0] a, input int n, output logic [39:0] v);
      logic [7:0] b;
      v = 40'h0000000000;
      for (int i = 0; i < n; i++)
      begin
         sfr_rd(a, b);
         v = {v[31:0], b};
      end
   endtask

   // counts the cycles busy stays high after the final operand access
   task wait_idle(input string what, input int n);
      int c;
      int i;
      i = 0;
      c = 0;
      while (busy !== 1'b1 && i < 8)
      begin
         @(posedge clk_in);
         i++;
      end
      do
      begin
         c++;
         @(posedge clk_in);
      end
      while (busy === 1'b1 && c < 400);
      check(what, c, n);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task t_div(input string what, input logic [31:0] n, input int nb, input logic [15:0] dv, input int cyc);
      logic [39:0] v;
      logic [7:0] b;
      sfr_wr(ADDR_OPA, n[7:0]);
      sfr_wr(8'hd0, 8'h5a); // unrelated register between operand bytes
      sfr_rd(8'hd0, b);
      load(ADDR_OPA, n >> 8, nb - 1);
      load(ADDR_OPB, {16'h0000, dv}, 2);
      wait_idle(what, cyc);
      fetch(ADDR_OPA, nb, v);
      check(what, v, n / dv);
      fetch(ADDR_OPB, 2, v);
      check(what, v, n % dv);
   endtask

   task t_fault;
      logic [31:0] q;
      logic e;
      logic [7:0] b;
      sfr_rd(ADDR_SHIFT_SETUP, b);
      check("setup reset", b, SETUP_RESET);
      apb(1'b0, 12'h008, 32'h00000000, q, e);
      check("unmapped", e, 1'b1);
      sfr_wr(ADDR_OPA, 8'h11);
      sfr_wr(ADDR_OPB, 8'h22); // divisor before the dividend is complete
      repeat (60) @(posedge clk_in);
      check("fault busy", busy, 1'b1);
      sfr_rd(ADDR_STATUS, b);
      check("status busy", b, 8'h80);
      sfr_wr(ADDR_STATUS, 8'h00);
      repeat (2) @(posedge clk_in);
      check("cleared", busy, 1'b0);
   endtask

   task t_mul;
      logic [39:0] v;
      load(ADDR_OPC, 32'h00000000, 4);
      sfr_wr(ADDR_OPC, 8'h01);
      load(ADDR_OPB, 32'h00001234, 2);
      load(ADDR_OPA, 32'h0000fedc, 2);
      wait_idle("mul busy", CYC_MUL);
      fetch(ADDR_OPA, 4, v);
      check("product", v, 32'h1234 * 32'hfedc);
      fetch(ADDR_OPC, 5, v);
      check("accumulator", v, 40'h0100000000 + 32'h1234 * 32'hfedc);
      check("accum_out", accum, 40'h0100000000 + 32'h1234 * 32'hfedc);
   endtask

   task t_shift(input string what, input logic [31:0] d, input logic [7:0] set, input logic [31:0] exp,
      input logic [7:0] set_exp);
      logic [39:0] v;
      logic [7:0] b;
      load(ADDR_OPA, d, 4);
      sfr_wr(ADDR_SHIFT_SETUP, set);
      wait_idle(what, CYC_SHIFT);
      fetch(ADDR_OPA, 4, v);
      check(what, v, exp);
      sfr_rd(ADDR_SHIFT_SETUP, b);
      check(what, b, set_exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      failures = 0;
      n_checks = 0;
      srst_in = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      repeat (3) @(posedge clk_in);
      srst_in <= 1'b0;
      t_div("div32", 32'h12345678, 4, 16'h0123, CYC_DIV32);
      t_div("div16", 32'h00009abc, 2, 16'h0034, CYC_DIV16);
      t_fault();
      t_mul();
      t_shift("shift left", 32'h80000001, 8'h84, 32'h00000010, 8'h84);
      t_shift("shift right", 32'h80000001, 8'h04, 32'h08000000, 8'h04);
      // normalize input kept nonzero, a zero value would never finish
      t_shift("normalize", 32'h00012345, 8'h00, 32'h91a28000, 8'h0f);
      complete_run();
   end

   // guard against a hang anywhere
   initial
   begin
      repeat (100000) @(posedge clk_in);
      hang();
   end
endmodule
